// ---- sdc_front_end.sv ----
`timescale 1ns/10ps
`include "sdc_map.svh"

module sdc_front_end (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_sck,
  input wire logic i_csn,
  input wire logic i_sdi,
  input wire logic i_low_power_request_pin,
  input wire logic i_serial_mode_select,
  input wire logic i_analog_base_select,
  input wire logic i_sense_compare_a,
  input wire logic i_sense_compare_b,
  input wire logic i_chop_start_a,
  input wire logic i_chop_start_b,
  input wire logic [2:0] i_load_value,
  input wire logic i_overheat_flag,
  input wire logic i_heat_prewarning_flag,
  input wire logic i_supply_low_flag,
  input wire logic i_high_side_overcurrent_flag,
  input wire logic i_open_coil_b_flag,
  input wire logic i_open_coil_a_flag,
  input wire logic i_low_side_overcurrent_b_flag,
  input wire logic i_low_side_overcurrent_a_flag,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [3:0] o_coil_a_level,
  output logic [3:0] o_coil_b_level,
  output logic o_mixed_decay_a,
  output logic o_mixed_decay_b,
  output logic o_bridge_a_polarity,
  output logic o_bridge_b_polarity,
  output logic o_bridge_a_on,
  output logic o_bridge_b_on,
  output logic o_chop_restart_a,
  output logic o_chop_restart_b,
  output logic [2:0] o_load_value,
  output logic o_standby,
  output logic o_references_on,
  output logic o_clear_errors,
  output logic o_use_analog_base
);

  localparam int SYNC_W = 19;
  localparam int SETTLE_W = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_W'(`SDC_LOAD_SETTLE_CYC);
  localparam logic [3:0] CNT_FULL = 4'(`SDC_WORD_BITS);

  initial
  begin
    if (`SDC_LOAD_SETTLE_CYC < 1 || `SDC_LOAD_SETTLE_CYC > 255)
    begin
      $error("load settle count does not fit its counter");
    end
  end

  // pin synchronisers into the system clock domain
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  assign pins_raw = {i_low_power_request_pin, i_serial_mode_select, i_analog_base_select,
                     i_sck, i_sdi, i_csn, i_sense_compare_a, i_sense_compare_b,
                     i_load_value, i_overheat_flag, i_heat_prewarning_flag,
                     i_supply_low_flag, i_high_side_overcurrent_flag,
                     i_open_coil_b_flag, i_open_coil_a_flag,
                     i_low_side_overcurrent_b_flag, i_low_side_overcurrent_a_flag};

  always_ff @(posedge i_mclk)
  begin
    sync1_q <= pins_raw;
    sync2_q <= sync1_q;
  end

  logic lp_s;
  logic spe_s;
  logic ann_s;
  logic sck_s;
  logic sdi_s;
  logic csn_s;
  logic sense_a_s;
  logic sense_b_s;
  logic [2:0] load_s;
  logic [7:0] flags_s;

  assign lp_s = sync2_q[18];
  assign spe_s = sync2_q[17];
  assign ann_s = sync2_q[16];
  assign sck_s = sync2_q[15];
  assign sdi_s = sync2_q[14];
  assign csn_s = sync2_q[13];
  assign sense_a_s = sync2_q[12];
  assign sense_b_s = sync2_q[11];
  assign load_s = sync2_q[10:8];
  assign flags_s = sync2_q[7:0];

  // status snapshot, frozen while a frame is open so the link sees a stable word
  logic [`SDC_WORD_BITS-1:0] snap_q;
  logic [2:0] load_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      snap_q <= `SDC_SETTINGS_RST;
    else if (csn_s)
      snap_q <= {load_q, 1'b1, flags_s};
  end

  // link domain: clocked by the serial clock, cleared by low-power request
  // or standalone mode; the data out stage is also cleared by select high
  logic link_rst;
  logic cap_rst;
  logic [3:0] cnt_q;
  logic [`SDC_WORD_BITS-1:0] shift_q;
  logic sdo_q;
  logic first_q;
  logic frame_tgl_q;
  logic frame_ack_q;
  logic new_frame;

  assign link_rst = i_csn | i_low_power_request_pin | ~i_serial_mode_select;
  assign cap_rst = i_low_power_request_pin | ~i_serial_mode_select;
  // a frame closed by select since the last shift: restart the count on this edge,
  // so select rise never races a reset of the count it reads
  assign new_frame = (frame_ack_q != frame_tgl_q) || (cnt_q == 4'h0);

  always_ff @(posedge i_sck or posedge cap_rst)
  begin
    if (cap_rst)
    begin
      cnt_q <= 4'h0;
      shift_q <= `SDC_SETTINGS_RST;
      frame_ack_q <= 1'b0;
    end
    else if (new_frame)
    begin
      cnt_q <= 4'h1;
      frame_ack_q <= frame_tgl_q;
      shift_q <= {snap_q[`SDC_WORD_BITS-2:0], i_sdi};
    end
    else
    begin
      if (cnt_q != CNT_FULL + 4'h1)
        cnt_q <= cnt_q + 4'h1;
      shift_q <= {shift_q[`SDC_WORD_BITS-2:0], i_sdi};
    end
  end

  always_ff @(negedge i_sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      sdo_q <= 1'b0;
      first_q <= 1'b1;
    end
    else
    begin
      sdo_q <= shift_q[`SDC_WORD_BITS-1];
      first_q <= 1'b0;
    end
  end

  // word capture on select rise; the toggle carries the event across
  logic [`SDC_WORD_BITS-1:0] cmd_q;
  logic cmd_tgl_q;

  always_ff @(posedge i_csn or posedge cap_rst)
  begin
    if (cap_rst)
    begin
      cmd_q <= `SDC_SETTINGS_RST;
      cmd_tgl_q <= 1'b0;
      frame_tgl_q <= 1'b0;
    end
    else
    begin
      frame_tgl_q <= ~frame_tgl_q;
      if (cnt_q >= CNT_FULL)
      begin
        cmd_q <= shift_q;
        cmd_tgl_q <= ~cmd_tgl_q;
      end
    end
  end

  logic tgl1_q;
  logic tgl2_q;
  logic tgl3_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      tgl1_q <= 1'b0;
      tgl2_q <= 1'b0;
      tgl3_q <= 1'b0;
    end
    else
    begin
      tgl1_q <= cmd_tgl_q;
      tgl2_q <= tgl1_q;
      tgl3_q <= tgl2_q;
    end
  end

  // held settings
  logic [`SDC_WORD_BITS-1:0] settings_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || lp_s || !spe_s)
      settings_q <= `SDC_SETTINGS_RST;
    else if (tgl2_q != tgl3_q)
      settings_q <= cmd_q;
  end

  // operating mode
  sdc_pkg::sdc_mode_t mode_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      mode_q <= sdc_pkg::SDC_MODE_SHUTDOWN;
    else if (!spe_s)
      mode_q <= sdc_pkg::SDC_MODE_STANDALONE;
    else if (lp_s)
      mode_q <= sdc_pkg::SDC_MODE_SHUTDOWN;
    else
      mode_q <= sdc_pkg::SDC_MODE_SERIAL;
  end

  // effective bridge controls
  logic [3:0] lvl_a_d;
  logic [3:0] lvl_b_d;
  logic md_a_d;
  logic md_b_d;
  logic pol_a_d;
  logic pol_b_d;

  always_comb
  begin
    case (mode_q)
      sdc_pkg::SDC_MODE_STANDALONE:
      begin
        lvl_a_d = `SDC_LEVEL_FULL;
        lvl_b_d = `SDC_LEVEL_FULL;
        md_a_d = ~ann_s;
        md_b_d = ~sck_s;
        pol_a_d = sdi_s;
        pol_b_d = csn_s;
      end
      sdc_pkg::SDC_MODE_SERIAL:
      begin
        lvl_a_d = settings_q[`SDC_CMD_LVL_A_HI:`SDC_CMD_LVL_A_LO];
        lvl_b_d = settings_q[`SDC_CMD_LVL_B_HI:`SDC_CMD_LVL_B_LO];
        md_a_d = settings_q[`SDC_CMD_MD_A];
        md_b_d = settings_q[`SDC_CMD_MD_B];
        pol_a_d = settings_q[`SDC_CMD_POL_A];
        pol_b_d = settings_q[`SDC_CMD_POL_B];
      end
      default:
      begin
        lvl_a_d = `SDC_LEVEL_OFF;
        lvl_b_d = `SDC_LEVEL_OFF;
        md_a_d = 1'b0;
        md_b_d = 1'b0;
        pol_a_d = 1'b0;
        pol_b_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_coil_a_level <= `SDC_LEVEL_OFF;
      o_coil_b_level <= `SDC_LEVEL_OFF;
      o_mixed_decay_a <= 1'b0;
      o_mixed_decay_b <= 1'b0;
      o_bridge_a_polarity <= 1'b0;
      o_bridge_b_polarity <= 1'b0;
      o_chop_restart_a <= 1'b0;
      o_chop_restart_b <= 1'b0;
    end
    else
    begin
      o_coil_a_level <= lvl_a_d;
      o_coil_b_level <= lvl_b_d;
      o_mixed_decay_a <= md_a_d;
      o_mixed_decay_b <= md_b_d;
      o_bridge_a_polarity <= pol_a_d;
      o_bridge_b_polarity <= pol_b_d;
      o_chop_restart_a <= pol_a_d != o_bridge_a_polarity;
      o_chop_restart_b <= pol_b_d != o_bridge_b_polarity;
    end
  end

  // chopper on phase: a period starts only if the sense comparator is quiet
  always_ff @(posedge i_mclk)
  begin
    if (i_reset || o_coil_a_level == `SDC_LEVEL_OFF)
      o_bridge_a_on <= 1'b0;
    else if (o_chop_restart_a || i_chop_start_a)
      o_bridge_a_on <= ~sense_a_s;
    else if (sense_a_s)
      o_bridge_a_on <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || o_coil_b_level == `SDC_LEVEL_OFF)
      o_bridge_b_on <= 1'b0;
    else if (o_chop_restart_b || i_chop_start_b)
      o_bridge_b_on <= ~sense_b_s;
    else if (sense_b_s)
      o_bridge_b_on <= 1'b0;
  end

  // load value: hold the old reading until the new polarity has settled
  logic [SETTLE_W-1:0] settle_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset || o_chop_restart_a || o_chop_restart_b)
      settle_q <= SETTLE_W'(0);
    else if (settle_q != SETTLE_CYC)
      settle_q <= settle_q + SETTLE_W'(1);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      load_q <= 3'h0;
    else if (settle_q == SETTLE_CYC)
      load_q <= load_s;
  end

  assign o_load_value = load_q;

  // standalone fault latch; a new fault wins over the clear
  logic lp_prev_q;
  logic fault_now;
  logic clr_ev;
  logic err_q;

  assign fault_now = flags_s[7] | flags_s[4] | flags_s[1] | flags_s[0];
  assign clr_ev = lp_s & ~lp_prev_q & (mode_q == sdc_pkg::SDC_MODE_STANDALONE);

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      lp_prev_q <= 1'b0;
      err_q <= 1'b0;
      o_clear_errors <= 1'b0;
    end
    else
    begin
      lp_prev_q <= lp_s;
      o_clear_errors <= clr_ev;
      if (fault_now)
        err_q <= 1'b1;
      else if (clr_ev)
        err_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_standby <= 1'b1;
      o_references_on <= 1'b0;
      o_use_analog_base <= 1'b0;
    end
    else
    begin
      o_standby <= lp_s;
      o_references_on <= ~(lp_s & spe_s);
      o_use_analog_base <= spe_s & ~ann_s;
    end
  end

  // data out: fault level in standalone, shifted status in serial
  always_comb
  begin
    if (!i_serial_mode_select)
    begin
      o_sdo = err_q;
      o_sdo_oe = 1'b1;
    end
    else
    begin
      o_sdo = first_q ? snap_q[`SDC_WORD_BITS-1] : sdo_q;
      o_sdo_oe = ~i_csn & ~i_low_power_request_pin;
    end
  end

endmodule : sdc_front_end

// ---- sdc_front_end_checker.sv ----
`timescale 1ns/10ps
module sdc_front_end_checker (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_sck,
  input wire logic i_csn,
  input wire logic i_low_power_request_pin,
  input wire logic i_serial_mode_select,
  input wire logic i_analog_base_select,
  input wire logic i_sense_compare_a,
  input wire logic i_chop_start_a,
  input wire logic o_sdo_oe,
  input wire logic [3:0] o_coil_a_level,
  input wire logic [3:0] o_coil_b_level,
  input wire logic o_mixed_decay_a,
  input wire logic o_mixed_decay_b,
  input wire logic o_bridge_a_polarity,
  input wire logic o_bridge_a_on,
  input wire logic o_chop_restart_a,
  input wire logic o_chop_restart_b,
  input wire logic [2:0] o_load_value,
  input wire logic o_standby,
  input wire logic o_references_on,
  input wire logic o_clear_errors
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [6:0] since_q;
  // cycles since the last chopper restart, saturating
  always_ff @(posedge i_mclk)
    if (i_reset)
      since_q <= 7'h7F;
    else if (o_chop_restart_a || o_chop_restart_b)
      since_q <= 7'h00;
    else if (since_q != 7'h7F)
      since_q <= since_q + 7'h01;
  sequence s_alone; !i_serial_mode_select [*6]; endsequence
  sequence s_idle; i_csn || i_low_power_request_pin; endsequence
  property p_float; i_serial_mode_select [*4] ##0 s_idle |-> !o_sdo_oe; endproperty
  property p_driven; s_alone |-> o_sdo_oe; endproperty
  property p_full; s_alone |-> o_coil_a_level == 4'hF && o_coil_b_level == 4'hF; endproperty
  property p_shut;
    (i_serial_mode_select && i_low_power_request_pin) [*6] |-> !o_references_on
      && o_coil_a_level == 4'h0 && o_coil_b_level == 4'h0;
  endproperty
  property p_mda; (!i_serial_mode_select && !i_analog_base_select) [*6] |-> o_mixed_decay_a;
  endproperty
  property p_mdb; (!i_serial_mode_select && !i_sck) [*6] |-> o_mixed_decay_b; endproperty
  property p_restart; $changed(o_bridge_a_polarity) |-> ##[0:1] o_chop_restart_a; endproperty
  property p_chop_off;
    i_sense_compare_a [*5] ##1 (i_sense_compare_a && i_chop_start_a) |=> !o_bridge_a_on;
  endproperty
  property p_clear; s_alone ##0 $rose(i_low_power_request_pin) |-> ##[1:5] o_clear_errors;
  endproperty
  property p_load; $changed(o_load_value) && !o_standby && $stable(o_standby) |-> since_q > 7'h62;
  endproperty
  a_float: assert property (p_float) else $error("sdo driven while idle");
  a_driven: assert property (p_driven) else $error("fault pin floats");
  a_full: assert property (p_full) else $error("levels not full");
  a_shut: assert property (p_shut) else $error("shutdown not held");
  a_mda: assert property (p_mda) else $error("decay a off");
  a_mdb: assert property (p_mdb) else $error("decay b off");
  a_restart: assert property (p_restart) else $error("no restart");
  a_chop_off: assert property (p_chop_off) else $error("bridge on while tripped");
  a_clear: assert property (p_clear) else $error("errors not cleared");
  a_load: assert property (p_load) else $error("load too early");
endmodule : sdc_front_end_checker

// ---- sdc_front_end_tb.sv ----
`timescale 1ns/10ps
module sdc_front_end_tb;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_low_power_request_pin = 1'b1;
  logic i_serial_mode_select = 1'b1, i_analog_base_select = 1'b1;
  logic i_sense_compare_a = 1'b0, i_sense_compare_b = 1'b0;
  logic i_chop_start_a = 1'b0, i_chop_start_b = 1'b0;
  logic [2:0] i_load_value = 3'h0;
  logic [7:0] flg = 8'h00, cyc = 8'h00;
  wire i_sck, i_csn, i_sdi;
  logic o_sdo, o_sdo_oe, o_mixed_decay_a, o_mixed_decay_b, o_bridge_a_polarity;
  logic o_bridge_b_polarity, o_bridge_a_on, o_bridge_b_on, o_chop_restart_a, o_chop_restart_b;
  logic o_standby, o_references_on, o_clear_errors, o_use_analog_base;
  logic [3:0] o_coil_a_level, o_coil_b_level;
  logic [2:0] o_load_value;
  wire i_overheat_flag = flg[7];
  wire i_heat_prewarning_flag = flg[6];
  wire i_supply_low_flag = flg[5];
  wire i_high_side_overcurrent_flag = flg[4];
  wire i_open_coil_b_flag = flg[3];
  wire i_open_coil_a_flag = flg[2];
  wire i_low_side_overcurrent_b_flag = flg[1];
  wire i_low_side_overcurrent_a_flag = flg[0];
  wire [11:0] cfg = {o_mixed_decay_a, o_coil_a_level, o_bridge_a_polarity,
    o_mixed_decay_b, o_coil_b_level, o_bridge_b_polarity};
  logic [31:0] rs = 32'h2F37B7D4;
  logic [15:0] w, r, e;
  int errors = 0, n_tests = 0, n;
  sdc_front_end i_dut (.*);
  sdc_host_model i_host (.i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_sck(i_sck), .o_csn(i_csn),
    .o_sdi(i_sdi));
  initial
    forever #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 8'h01;
    i_chop_start_a <= cyc[3:0] == 4'hE;
    i_chop_start_b <= cyc[3:0] == 4'h6;
    i_sense_compare_a <= cyc[6];
    i_sense_compare_b <= cyc[7];
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : nxt
  function automatic logic [15:0] exp_st(input logic [2:0] l, input logic [7:0] f);
    return {4'h0, l, 1'b1, f};
  endfunction : exp_st
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
  endtask : tick
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    tick(20);
    i_reset <= 1'b0;
    tick(10);
    cmp({o_references_on, cfg}, 16'h0000);
    rs = nxt(rs);
    i_load_value <= rs[2:0];
    i_low_power_request_pin <= 1'b0;
    tick(600);
    for (int k = 0; k < 7; k++)
    begin
      rs = nxt(rs);
      flg <= rs[23:16];
      w = (k == 0) ? 16'h0FFF : {4'hA, rs[11:0]};
      n = k[0] ? 16 : 12;
      tick(2);
      i_host.xfer(w, n, r);
      tick(120);
      e = exp_st(i_load_value, flg);
      if (k > 0)
        cmp(r, (n == 16) ? {e[11:0], w[15:12]} : e);
      cmp(cfg, {4'h0, w[11:0]});
      $display("word %0d done", k);
    end
    i_host.xfer(16'h0000, 11, r);
    tick(20);
    cmp(cfg, {4'h0, w[11:0]});
    i_low_power_request_pin <= 1'b1;
    tick(10);
    cmp({o_references_on, cfg}, 16'h0000);
    i_host.xfer(16'h0FFF, 12, r);
    i_low_power_request_pin <= 1'b0;
    tick(600);
    cmp(cfg, 16'h0000);
    $display("serial tests done");
    i_serial_mode_select <= 1'b0;
    i_analog_base_select <= 1'b0;
    i_host.o_csn <= 1'b0;
    i_host.o_sdi <= 1'b1;
    flg <= 8'h80;
    tick(10);
    cmp({o_coil_a_level, o_coil_b_level}, 16'h00FF);
    cmp({o_mixed_decay_a, o_mixed_decay_b, o_bridge_a_polarity, o_bridge_b_polarity, o_sdo},
      16'h001D);
    flg <= 8'h00;
    tick(5);
    cmp(o_sdo, 16'h0001);
    i_low_power_request_pin <= 1'b1;
    tick(10);
    cmp(o_sdo, 16'h0000);
    $display("standalone tests done");
    tally_and_finish();
  end
  initial
  begin
    #3000000;
    errors++;
    tally_and_finish();
  end
endmodule : sdc_front_end_tb
bind sdc_front_end sdc_front_end_checker i_chk (.*);

// ---- sdc_host_model.sv ----
`timescale 1ns/10ps
module sdc_host_model (
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sck,
  output logic o_csn,
  output logic o_sdi
);
  logic last_q = 1'b0;
  // a released line shows the inverse of its last value
  wire line = i_sdo_oe ? i_sdo : ~last_q;
  initial
  begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_csn = 1'b0;
    #213;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdi = w[i];
      #80 o_sck = 1'b1;
      r = {r[14:0], line};
      last_q = line;
      #80 o_sck = 1'b0;
    end
    #80 o_csn = 1'b1;
    o_sdi = ~o_sdi;
    #300;
  endtask : xfer
endmodule : sdc_host_model

// ---- sdc_map.svh ----
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// command word layout, msb shifted first
`define SDC_WORD_BITS 12
`define SDC_CMD_MD_A 11
`define SDC_CMD_LVL_A_HI 10
`define SDC_CMD_LVL_A_LO 7
`define SDC_CMD_POL_A 6
`define SDC_CMD_MD_B 5
`define SDC_CMD_LVL_B_HI 4
`define SDC_CMD_LVL_B_LO 1
`define SDC_CMD_POL_B 0

// status word layout
`define SDC_ST_LOAD_HI 11
`define SDC_ST_LOAD_LO 9
`define SDC_ST_ONE 8

// reset values and fixed codes
`define SDC_SETTINGS_RST 12'h000
`define SDC_LEVEL_FULL 4'hF
`define SDC_LEVEL_OFF 4'h0

// timing
`define SDC_MCLK_NS 50
`define SDC_LOAD_SETTLE_NS 5000
`define SDC_LOAD_SETTLE_CYC ((`SDC_LOAD_SETTLE_NS) / (`SDC_MCLK_NS))

`endif

// ---- sdc_pkg.sv ----
package sdc_pkg;

  // gray coded along shutdown -> serial -> standalone
  typedef enum logic [1:0] {
    SDC_MODE_SHUTDOWN = 2'h0,
    SDC_MODE_SERIAL = 2'h1,
    SDC_MODE_STANDALONE = 2'h3
  } sdc_mode_t;

endpackage : sdc_pkg
